// >>> common/mgmt_virt_pkg.sv
package mgmt_virt_pkg;

    // register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS    = 8'h00;
    localparam logic [7:0] STATUS_OFS  = 8'h04;
    localparam logic [7:0] CAPS_OFS    = 8'h08;
    localparam logic [7:0] GSTAT_OFS   = 8'h0C;
    localparam logic [7:0] EPTLO_OFS   = 8'h10;
    localparam logic [7:0] EPTHI_OFS   = 8'h14;
    localparam logic [7:0] CRIT_OFS    = 8'h18;
    localparam logic [7:0] SAVEFLG_OFS = 8'h1C;
    localparam logic [7:0] SVPLO_OFS   = 8'h20;
    localparam logic [7:0] SVPHI_OFS   = 8'h24;
    localparam logic [7:0] VCSLO_OFS   = 8'h28;
    localparam logic [7:0] VCSHI_OFS   = 8'h2C;
    localparam logic [7:0] OUTS_OFS    = 8'h30;

    // save-area offsets relative to mgmt_base
    localparam logic [15:0] EPT_FLAG_SAVE_OFS = 16'hFEE0;
    localparam logic [15:0] EPT_PTR_SAVE_OFS  = 16'hFED8;

    // bit positions
    localparam int PRIMARY_SECONDARY_BIT = 31;
    localparam int ROOT_ADDR_LSB         = 12;
    localparam int ROOT_ADDR_MSB         = 51;
    localparam logic [15:0] HOST_TAG     = 16'h0000;

    // reset values
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] CAPS_RST = 32'h0000_0003;

    typedef enum logic [1:0] {
        OP_NONE,
        OP_ROOT,
        OP_NONROOT
    } virt_op_t;

    typedef enum {
        ST_NORMAL,
        ST_ENTER,
        ST_SAVE,
        ST_IN_MGMT,
        ST_RESTORE,
        ST_SHUTDOWN
    } seq_state_t;

    // virtualization-critical state
    typedef struct packed {
        logic [1:0] stackPrivLevel;
        logic       v86Flag;
        logic       stackLoadShadow;
        logic       intEnableShadow;
        logic       vnmiBlock;
        logic       mtfPending;
    } crit_state_t;

    // processor-side status produced by the sequencer
    typedef struct packed {
        logic initBlock;
        logic nmiBlock;
        logic mgmtIntBlock;
        logic a20Blocked;
        logic privLocked;
        logic inMgmt;
        logic shutdown;
        logic mtfExitPend;
        logic winExitReq;
        logic wakeHalt;
    } cpu_out_t;

endpackage : mgmt_virt_pkg

// >>> verilog/mgmt_mode_virt_entry_exit.sv
// The placing of the registers and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - record prior enable bit and operation kind
// - in virt operation: save pointer, exit, save
// - remember private-space lock, lock if unlocked
// - clear enable, save state, load standard state
// - drop host-tag translations, all roots
// - standard state blocks INIT, NMI, interrupts
// - save privilege, v86, shadows, vnmi, trap flag
// - save ext-table control bit, else zero
// - bit one also saves table pointer
// - primary bit 31 low disables table control
// - image enable bit set: shutdown
// - restore, invalidate all tags and roots
// - unlock if was unlocked; restore enable bit
// - re-enter operation, fix bits, restore pointer
// - copy stack privilege into request privileges
// - block address mask in virt/safer operation
// - unblock interrupts; NMI restore per vnmi
// - INIT blocked only in root operation
// - non-root: window exits requested after resume
// - unrestricted guest keeps protect/paging bits
// - trap exit pending after resume, priority
// - trap exit wakes halt, not shutdown
module mgmt_mode_virt_entry_exit
    import mgmt_virt_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        mgmtIntReq,
    input  wire logic        resumeReq,
    input  wire logic        higherPrioEvent,
    input  wire logic        enteredHalt,
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output cpu_out_t         cpuOut_q,
    output logic             invalidateHost_q,
    output logic             invalidateAll_q
);

    ////////////////////////////////////////////////////////////////////////////
    // software-visible guest state
    // ctrl: 0 virt_ext_enable, 1 in op, 2 non-root, 3 ext-table ctrl, 4 primary31,
    //       5 unrestricted, 6 virtual NMIs, 7 int-window, 8 nmi-window,
    //       9 private unlocked, 10 image enable, 11 saferMode op,
    //       12 protect_enable, 13 paging_enable, 14 nmi blocked, 15 window cond
    logic [31:0] ctrl_q;
    logic [31:0] eptLo_q;
    logic [31:0] eptHi_q;
    logic [31:0] vcsLo_q;
    logic [31:0] vcsHi_q;
    crit_state_t crit_q;
    logic [31:0] caps_q;

    ////////////////////////////////////////////////////////////////////////////
    // internally saved indications
    logic        svEnable_q;
    virt_op_t    svOp_q;
    logic [63:0] svStruct_q;
    logic        svUnlocked_q;
    crit_state_t svCrit_q;
    logic        svEptFlag_q;
    logic [63:0] svEptPtr_q;
    logic [1:0]  codeReqPriv_q;
    logic [1:0]  stackReqPriv_q;
    logic [1:0]  fixedPePg_q;

    seq_state_t  state_q;
    logic        eptEffective;
    logic        resumeRoot;
    logic        resumeNonroot;

    assign eptEffective  = ctrl_q[3] & ctrl_q[PRIMARY_SECONDARY_BIT - 27] & caps_q[0];
    assign resumeRoot    = (svOp_q == OP_ROOT);
    assign resumeNonroot = (svOp_q == OP_NONROOT);

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= ST_NORMAL;
        end else begin
            case (state_q)
                ST_NORMAL:   if (mgmtIntReq) state_q <= ST_ENTER;
                ST_ENTER:    state_q <= ST_SAVE;
                ST_SAVE:     state_q <= ST_IN_MGMT;
                ST_IN_MGMT: begin
                    if (resumeReq) begin
                        if (ctrl_q[10]) state_q <= ST_SHUTDOWN;
                        else state_q <= ST_RESTORE;
                    end
                end
                ST_RESTORE:  state_q <= ST_NORMAL;
                default:     state_q <= ST_SHUTDOWN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // entry capture, held through management mode
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            svEnable_q   <= 1'b0;
            svOp_q       <= OP_NONE;
            svStruct_q   <= 64'h0;
            svUnlocked_q <= 1'b0;
            svCrit_q     <= '0;
            svEptFlag_q  <= 1'b0;
            svEptPtr_q   <= 64'h0;
        end else if (state_q == ST_ENTER) begin
            svEnable_q <= ctrl_q[0];
            svOp_q     <= !ctrl_q[1] ? OP_NONE : (ctrl_q[2] ? OP_NONROOT : OP_ROOT);
            if (ctrl_q[1]) begin
                svStruct_q <= {vcsHi_q, vcsLo_q};
                svCrit_q   <= '{stackPrivLevel: crit_q.stackPrivLevel,
                                v86Flag:         crit_q.v86Flag,
                                stackLoadShadow: crit_q.stackLoadShadow,
                                intEnableShadow: crit_q.intEnableShadow,
                                vnmiBlock:       crit_q.vnmiBlock & ctrl_q[2] & ctrl_q[6],
                                mtfPending:      crit_q.mtfPending};
            end
            svUnlocked_q <= caps_q[1] & ctrl_q[9];
            svEptFlag_q  <= ctrl_q[1] & ctrl_q[2] & eptEffective;
            if (ctrl_q[1] & ctrl_q[2] & eptEffective) begin
                svEptPtr_q <= {eptHi_q, eptLo_q};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // guest state: software writes, sequencer updates
    logic        wrFire;
    logic [31:0] wrAddr_q;
    logic [31:0] wrData_q;
    logic        awHeld_q;
    logic        wHeld_q;
    assign wrFire = awHeld_q & wHeld_q & !s_axi_bvalid;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ctrl_q  <= CTRL_RST;
            eptLo_q <= 32'h0;
            eptHi_q <= 32'h0;
            vcsLo_q <= 32'h0;
            vcsHi_q <= 32'h0;
            crit_q  <= '0;
            caps_q  <= CAPS_RST;
        end else if (state_q == ST_SAVE) begin
            ctrl_q[0]  <= 1'b0;
            ctrl_q[1]  <= 1'b0;
            ctrl_q[2]  <= 1'b0;
            ctrl_q[9]  <= 1'b0;
            // prior nmi blocking kept here so resume can restore it normally
        end else if (state_q == ST_RESTORE) begin
            ctrl_q[0] <= svEnable_q;
            ctrl_q[9] <= svUnlocked_q;
            ctrl_q[1] <= (svOp_q != OP_NONE);
            ctrl_q[2] <= resumeNonroot;
            ctrl_q[14] <= !(resumeNonroot & ctrl_q[6]) & ctrl_q[14];
            if (svOp_q != OP_NONE) begin
                crit_q            <= svCrit_q;
                {vcsHi_q, vcsLo_q} <= svStruct_q;
                ctrl_q[0] <= 1'b1; // fixed bit while in virt operation
                if (!(resumeNonroot & ctrl_q[5] & ctrl_q[PRIMARY_SECONDARY_BIT - 27])) begin
                    ctrl_q[12] <= fixedPePg_q[0] | ctrl_q[12];
                    ctrl_q[13] <= fixedPePg_q[1] | ctrl_q[13];
                end
            end
        end else if (wrFire) begin
            if (wrAddr_q[7:0] == CTRL_OFS) ctrl_q <= wrData_q;
            else if (wrAddr_q[7:0] == CAPS_OFS) caps_q <= wrData_q;
            else if (wrAddr_q[7:0] == EPTLO_OFS) eptLo_q <= wrData_q;
            else if (wrAddr_q[7:0] == EPTHI_OFS) eptHi_q <= wrData_q;
            else if (wrAddr_q[7:0] == CRIT_OFS) crit_q <= wrData_q[6:0];
            else if (wrAddr_q[7:0] == VCSLO_OFS) vcsLo_q <= wrData_q;
            else if (wrAddr_q[7:0] == VCSHI_OFS) vcsHi_q <= wrData_q;
        end
    end

    // fixed protect/paging requirement comes from capability bits 3:2
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) fixedPePg_q <= 2'b00;
        else fixedPePg_q <= caps_q[3:2];
    end

    // request privileges on re-entry
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            codeReqPriv_q  <= 2'b00;
            stackReqPriv_q <= 2'b00;
        end else if (state_q == ST_RESTORE && svOp_q != OP_NONE && !svCrit_q.v86Flag
                     && (resumeRoot || !(ctrl_q[5] & ctrl_q[PRIMARY_SECONDARY_BIT - 27]))) begin
            codeReqPriv_q  <= svCrit_q.stackPrivLevel;
            stackReqPriv_q <= svCrit_q.stackPrivLevel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // processor-side outputs
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cpuOut_q         <= '0;
            invalidateHost_q <= 1'b0;
            invalidateAll_q  <= 1'b0;
        end else begin
            invalidateHost_q <= (state_q == ST_SAVE);
            invalidateAll_q  <= (state_q == ST_RESTORE);
            cpuOut_q.shutdown <= cpuOut_q.shutdown | (state_q == ST_IN_MGMT & resumeReq
                                                      & ctrl_q[10]);
            cpuOut_q.wakeHalt <= 1'b0;
            if (state_q == ST_ENTER) begin
                cpuOut_q.inMgmt       <= 1'b1;
                cpuOut_q.initBlock    <= 1'b1;
                cpuOut_q.nmiBlock     <= 1'b1;
                cpuOut_q.mgmtIntBlock <= 1'b1;
                cpuOut_q.privLocked   <= caps_q[1] ? 1'b1 : cpuOut_q.privLocked;
                cpuOut_q.mtfExitPend  <= 1'b0;
                cpuOut_q.winExitReq   <= 1'b0;
            end else if (state_q == ST_RESTORE) begin
                cpuOut_q.inMgmt       <= 1'b0;
                cpuOut_q.mgmtIntBlock <= 1'b0;
                cpuOut_q.nmiBlock     <= resumeNonroot & ctrl_q[6] ? 1'b0 : ctrl_q[14];
                cpuOut_q.initBlock    <= resumeRoot;
                cpuOut_q.privLocked   <= caps_q[1] ? !svUnlocked_q : cpuOut_q.privLocked;
                cpuOut_q.a20Blocked   <= (svOp_q != OP_NONE) | ctrl_q[11];
                cpuOut_q.winExitReq   <= resumeNonroot & (ctrl_q[7] | ctrl_q[8]) & ctrl_q[15];
                cpuOut_q.mtfExitPend  <= svCrit_q.mtfPending & (svOp_q != OP_NONE);
                cpuOut_q.wakeHalt     <= svCrit_q.mtfPending & (svOp_q != OP_NONE) & enteredHalt;
            end else if (cpuOut_q.shutdown) begin
                cpuOut_q.mtfExitPend <= 1'b0;
            end else if (cpuOut_q.mtfExitPend && !mgmtIntReq && !higherPrioEvent) begin
                cpuOut_q.mtfExitPend <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite write channel
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            wrAddr_q      <= 32'h0;
            wrData_q      <= 32'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= 2'b00;
        end else begin
            s_axi_awready <= !awHeld_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !wHeld_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                wrAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q  <= 1'b1;
                wrData_q <= s_axi_wdata;
            end
            if (wrFire) begin
                awHeld_q     <= 1'b0;
                wHeld_q      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= (wrAddr_q[7:0] > VCSHI_OFS || wrAddr_q[1:0] != 2'b00
                                 || s_axi_wstrb != 4'hF) ? 2'b10 : 2'b00;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // axi4-lite read channel
    logic [31:0] rdMux;
    logic        rdOk;
    always_comb begin
        rdMux = 32'h0;
        rdOk  = 1'b1;
        if (s_axi_araddr[7:0] == CTRL_OFS) rdMux = ctrl_q;
        else if (s_axi_araddr[7:0] == STATUS_OFS) rdMux = {29'h0, 3'(state_q)};
        else if (s_axi_araddr[7:0] == CAPS_OFS) rdMux = caps_q;
        else if (s_axi_araddr[7:0] == GSTAT_OFS) rdMux = {26'h0, fixedPePg_q, codeReqPriv_q, stackReqPriv_q};
        else if (s_axi_araddr[7:0] == EPTLO_OFS) rdMux = eptLo_q;
        else if (s_axi_araddr[7:0] == EPTHI_OFS) rdMux = eptHi_q;
        else if (s_axi_araddr[7:0] == CRIT_OFS) rdMux = {25'h0, crit_q};
        else if (s_axi_araddr[7:0] == SAVEFLG_OFS) rdMux = {20'h0, svCrit_q, svUnlocked_q, svOp_q, svEnable_q, svEptFlag_q};
        else if (s_axi_araddr[7:0] == SVPLO_OFS) rdMux = svEptPtr_q[31:0];
        else if (s_axi_araddr[7:0] == SVPHI_OFS) rdMux = svEptPtr_q[63:32];
        else if (s_axi_araddr[7:0] == VCSLO_OFS) rdMux = vcsLo_q;
        else if (s_axi_araddr[7:0] == VCSHI_OFS) rdMux = vcsHi_q;
        else if (s_axi_araddr[7:0] == OUTS_OFS) rdMux = {22'h0, cpuOut_q};
        else rdOk = 1'b0;
        if (s_axi_araddr[31:8] != 24'h0) rdOk = 1'b0;
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= 2'b00;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rdOk ? rdMux : 32'h0;
                s_axi_rresp  <= rdOk ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : mgmt_mode_virt_entry_exit

// >>> verif/platform_irq_source.sv
`timescale 1ns/1ps
// platform side: raises the management request as a level after a delay, then drops it
module platform_irq_source (
    input  wire logic       clk_sys,
    input  wire logic       rst,
    input  wire logic       fire,
    input  wire logic [3:0] delayCycles,
    input  wire logic [3:0] holdCycles,
    output logic            mgmtIntReq
);
    logic [4:0] cnt_q;
    logic       armed_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            armed_q    <= 1'b0;
            cnt_q      <= 5'h00;
            mgmtIntReq <= 1'b0;
        end else if (fire) begin
            armed_q <= 1'b1;
            cnt_q   <= {1'b0, delayCycles};
        end else if (armed_q && cnt_q == 5'h00) begin
            armed_q    <= 1'b0;
            mgmtIntReq <= 1'b1;
            cnt_q      <= {1'b0, holdCycles};
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
        end else begin
            mgmtIntReq <= 1'b0;
        end
    end
endmodule : platform_irq_source

// >>> verif/mgmt_virt_props.sv
`timescale 1ns/1ps
module mgmt_virt_props
    import mgmt_virt_pkg::*;
(
    input wire logic     clk_sys,
    input wire logic     rst,
    input wire logic     mgmtIntReq,
    input wire logic     resumeReq,
    input wire cpu_out_t cpuOut_q,
    input wire logic     invalidateHost_q,
    input wire logic     invalidateAll_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////
    sequence smi_taken;
        $rose(mgmtIntReq) && !cpuOut_q.inMgmt && !cpuOut_q.mgmtIntBlock && !cpuOut_q.shutdown;
    endsequence
    sequence entered;
        $rose(cpuOut_q.inMgmt);
    endsequence
    sequence no_recent_resume;
        !resumeReq && !$past(resumeReq) && !$past(resumeReq, 2);
    endsequence
    ////////////////////////////////////////////////////////////////
    reset_clear_a: assert property ($fell(rst) |-> cpuOut_q == '0 && !invalidateAll_q)
        else $error("outputs not clear after reset");
    entry_latency_a: assert property (smi_taken |-> ##[1:4] cpuOut_q.mgmtIntBlock)
        else $error("entry blocks late");
    entry_block_a: assert property (entered |-> cpuOut_q.initBlock && cpuOut_q.nmiBlock
        && cpuOut_q.mgmtIntBlock)
        else $error("entry without blocks");
    host_inval_a: assert property ($rose(cpuOut_q.mgmtIntBlock) |-> ##[0:2] invalidateHost_q)
        else $error("no host invalidate on entry");
    host_pulse_a: assert property (invalidateHost_q |=> !invalidateHost_q)
        else $error("host invalidate longer than a pulse");
    priv_lock_a: assert property (entered |-> ##[0:1] cpuOut_q.privLocked)
        else $error("private space not locked");
    mgmt_hold_a: assert property (cpuOut_q.inMgmt && !cpuOut_q.shutdown ##0 no_recent_resume
        |=> cpuOut_q.inMgmt)
        else $error("left management mode without resume");
    shutdown_sticky_a: assert property (cpuOut_q.shutdown |=> cpuOut_q.shutdown)
        else $error("shutdown released");
    no_restore_a: assert property (cpuOut_q.shutdown |-> !invalidateAll_q)
        else $error("restore seen in shutdown");
    resume_unblock_a: assert property (invalidateAll_q |-> ##[0:1] !cpuOut_q.mgmtIntBlock
        && !cpuOut_q.inMgmt)
        else $error("resume left interrupts blocked");
endmodule : mgmt_virt_props

bind mgmt_mode_virt_entry_exit mgmt_virt_props u_props (.clk_sys(clk_sys), .rst(rst),
    .mgmtIntReq(mgmtIntReq), .resumeReq(resumeReq), .cpuOut_q(cpuOut_q),
    .invalidateHost_q(invalidateHost_q), .invalidateAll_q(invalidateAll_q));

// >>> verif/mgmt_mode_virt_entry_exit_test.sv
`timescale 1ns/1ps
module mgmt_mode_virt_entry_exit_test import mgmt_virt_pkg::*;;
    logic        clk_sys = 1'b0, rst = 1'b1, resumeReq = 1'b0, fire = 1'b0, mgmtIntReq;
    logic [3:0]  delayCycles = 4'h0;
    logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, invHost, invAll;
    logic [1:0]  bresp, rresp;
    cpu_out_t    cpuOut;
    int          mismatches = 0, n_tests = 0, cycles = 0, hostCnt = 0, allCnt = 0;

    mgmt_mode_virt_entry_exit u_dut (.clk_sys(clk_sys), .rst(rst), .mgmtIntReq(mgmtIntReq),
        .resumeReq(resumeReq), .higherPrioEvent(1'b0), .enteredHalt(1'b0),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cpuOut_q(cpuOut), .invalidateHost_q(invHost), .invalidateAll_q(invAll));
    platform_irq_source u_plat (.clk_sys(clk_sys), .rst(rst), .fire(fire),
        .delayCycles(delayCycles), .holdCycles(4'h6), .mgmtIntReq(mgmtIntReq));

    always #5 clk_sys = ~clk_sys;
    ////////////////////////////////////////////////////////////////
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (invHost === 1'b1) hostCnt <= hostCnt + 1;
        if (invAll === 1'b1) allCnt <= allCnt + 1;
        if (cycles == 4000) begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check
    ////////////////////////////////////////////////////////////////
    task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask : axi_wr

    task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk_sys);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge clk_sys);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask : axi_rd

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd({24'h0, a}, d, r);
        check({30'h0, r}, 32'h0, what);
        check(d, exp, what);
    endtask : rd_chk

    task automatic wait_mgmt(input logic lvl);
        int n;
        n = 0;
        while (cpuOut.inMgmt !== lvl && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        check({31'h0, cpuOut.inMgmt}, {31'h0, lvl}, "inMgmt");
    endtask : wait_mgmt
    ////////////////////////////////////////////////////////////////
    task automatic test_reset();
        logic [31:0] d;
        logic [1:0]  r;
        rd_chk(CAPS_OFS, CAPS_RST, "caps");
        rd_chk(CTRL_OFS, CTRL_RST, "ctrl");
        rd_chk(STATUS_OFS, 32'h0, "status");
        rd_chk(OUTS_OFS, 32'h0, "outs");
        axi_rd(32'h0000_0040, d, r);
        check({30'h0, r}, 32'h2, "unmapped read");
        axi_wr(32'h0000_0040, 32'h0000_FFFF, r);
        check({30'h0, r}, 32'h2, "unmapped write");
        $display("reset test done");
    endtask : test_reset

    task automatic test_entry(input logic [3:0] dly);
        int          h;
        logic [31:0] d;
        logic [1:0]  r;
        h = hostCnt;
        delayCycles <= dly;
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
        wait_mgmt(1'b1);
        // request still held by the platform here and must be ignored
        repeat (8) @(posedge clk_sys);
        check({29'h0, cpuOut.initBlock, cpuOut.nmiBlock, cpuOut.mgmtIntBlock}, 32'h7, "blk");
        check({31'h0, cpuOut.privLocked}, 32'h1, "lock");
        check(32'(hostCnt - h), 32'h1, "host invalidate");
        rd_chk(STATUS_OFS, 32'h3, "status mgmt");
        axi_rd({24'h0, SAVEFLG_OFS}, d, r);
        check({31'h0, d[0]}, 32'h0, "ept save bit");
        $display("entry test done");
    endtask : test_entry

    task automatic test_resume();
        int a;
        a = allCnt;
        resumeReq <= 1'b1;
        @(posedge clk_sys);
        resumeReq <= 1'b0;
        wait_mgmt(1'b0);
        repeat (2) @(posedge clk_sys);
        check(32'(allCnt - a), 32'h1, "full invalidate");
        check({31'h0, cpuOut.mgmtIntBlock}, 32'h0, "smi unblock");
        check({31'h0, cpuOut.nmiBlock}, 32'h0, "nmi unblock");
        check({31'h0, cpuOut.initBlock}, 32'h0, "init outside root");
        rd_chk(STATUS_OFS, 32'h0, "status normal");
        $display("resume test done");
    endtask : test_resume

    task automatic test_shutdown();
        int         a;
        logic [1:0] r;
        test_entry(4'h2);
        axi_wr({24'h0, CTRL_OFS}, 32'h0000_0400, r);
        check({30'h0, r}, 32'h0, "ctrl write");
        a = allCnt;
        resumeReq <= 1'b1;
        @(posedge clk_sys);
        resumeReq <= 1'b0;
        repeat (3) @(posedge clk_sys);
        check({31'h0, cpuOut.shutdown}, 32'h1, "shutdown");
        rd_chk(STATUS_OFS, 32'h5, "status shutdown");
        fire <= 1'b1;
        @(posedge clk_sys);
        fire <= 1'b0;
        repeat (12) @(posedge clk_sys);
        check({31'h0, cpuOut.shutdown}, 32'h1, "shutdown held");
        check(32'(allCnt - a), 32'h0, "no restore");
        $display("shutdown test done");
    endtask : test_shutdown
    ////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        test_reset();
        test_entry(4'h0);
        test_resume();
        test_entry(4'h5);
        test_resume();
        test_shutdown();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        test_reset();
        report_and_stop();
    end
endmodule : mgmt_mode_virt_entry_exit_test
